// ==== rtl/sdt_timer.sv ====
// Dual channel 16-bit down timer with a classic Wishbone register slave.
module sdt_timer
   import sdt_pkg::*;
(
   input  wire logic              clk_sys,
   input  wire logic              rstn,
   input  wire logic              wbCycI,
   input  wire logic              wbStbI,
   input  wire logic              wbWeI,
   input  wire logic [ADR_W-1:0]  wbAdrI,
   input  wire logic [3:0]        wbSelI,
   input  wire logic [31:0]       wbDatI,
   output logic [31:0]            wbDatO,
   output logic                   wbAckO,
   input  wire logic              lowFreqClock,
   output logic                   irq
);

   sdt_state_t st;
   sdt_state_t next_st;

   // ************************************************************
   // Next state
   // ************************************************************
   always_comb
   begin
      logic                 access;
      logic                 wr;
      logic [11:0]          adr;
      logic [31:0]          wmask;
      logic [31:0]          wdat;
      logic [31:0]          rdat;
      logic                 lowFreqRise;
      logic                 stage1;
      logic                 tick;
      logic                 enCmd;
      logic                 disCmd;
      logic [NUM_FLAGS-1:0] setFlags;
      logic [NUM_FLAGS-1:0] clrFlags;
      logic [15:0]          powLimit;
      logic [11:0]          coreLimit;
      access      = 1'b0;
      wr          = 1'b0;
      adr         = 12'h000;
      wmask       = 32'h00000000;
      wdat        = 32'h00000000;
      rdat        = 32'h00000000;
      lowFreqRise = 1'b0;
      stage1      = 1'b0;
      tick        = 1'b0;
      enCmd       = 1'b0;
      disCmd      = 1'b0;
      setFlags    = '0;
      clrFlags    = '0;
      powLimit    = 16'h0000;
      coreLimit   = 12'h000;
      next_st     = st;

      access = wbCycI && wbStbI && !st.ack;
      wr     = access && wbWeI;
      adr    = {wbAdrI[11:2], 2'b00};
      wmask  = {{8{wbSelI[3]}}, {8{wbSelI[2]}}, {8{wbSelI[1]}}, {8{wbSelI[0]}}};
      wdat   = wbDatI & wmask;
      lowFreqRise = lowFreqClock && !st.lowFreqPrev;
      next_st.lowFreqPrev = lowFreqClock;

      // A soft reset clears everything but the clock power flag.
      if (wr && adr == OFF_CONTROL && wdat[BIT_SOFT_RESET])
      begin
         next_st.ch      = '0;
         next_st.flags   = '0;
         next_st.irqMask = '0;
      end
      else
      begin
         for (int c = 0; c < NUM_CH; c++)
         begin
            // ************************************************************
            // Register writes to the channel
            // ************************************************************
            // Settings are frozen while the channel runs so the dividers never see a torn value.
            if (wr && !st.ch[c].channelOn && adr == OFF_CH0_PRESC + CH_STRIDE * 12'(c))
            begin
               next_st.ch[c].prescale            = wdat[PS_HI:PS_LO];
               next_st.ch[c].dividerSourceSelect = wdat[PS_SEL];
               next_st.ch[c].autoReloadOn        = wdat[PS_AUTO];
               next_st.ch[c].coreDivideValue     = wdat[SC_HI:SC_LO];
            end
            if (wr && !st.ch[c].channelOn && adr == OFF_CH0_PRELOAD + CH_STRIDE * 12'(c))
            begin
               next_st.ch[c].preload        = (st.ch[c].preload & ~wmask[15:0]) | wdat[15:0];
               next_st.ch[c].preloadPending = 1'b1;
            end

            // ************************************************************
            // Enable and disable commands
            // ************************************************************
            enCmd  = wr && adr == OFF_CONTROL && wdat[BIT_CH_ENABLE + CH_CMD_STRIDE * c];
            disCmd = wr && adr == OFF_CONTROL && wdat[BIT_CH_DISABLE + CH_CMD_STRIDE * c];
            if (disCmd)
            begin
               next_st.ch[c].channelOn = 1'b0;
               next_st.ch[c].coreDiv   = 12'h000;
               next_st.ch[c].powDiv    = 16'h0000;
               setFlags[BIT_DIS + CH_FLAG_STRIDE * c] = 1'b1;
            end
            else if (enCmd && !st.ch[c].channelOn)
            begin
               next_st.ch[c].channelOn = 1'b1;
               // Without a fresh preload the held count resumes.
               if (st.ch[c].preloadPending)
               begin
                  next_st.ch[c].count          = st.ch[c].preload;
                  next_st.ch[c].preloadPending = 1'b0;
               end
               setFlags[BIT_LOAD + CH_FLAG_STRIDE * c] = 1'b1;
            end

            // ************************************************************
            // Cascaded dividers and down-counter
            // ************************************************************
            // A stopped peripheral clock freezes the dividers and the count in place.
            else if (st.ch[c].channelOn && st.timerClockOn)
            begin
               coreLimit = {st.ch[c].coreDivideValue, 1'b1};
               if (st.ch[c].dividerSourceSelect)
               begin
                  stage1 = lowFreqRise;
               end
               else
               begin
                  stage1 = st.ch[c].coreDiv == coreLimit;
                  next_st.ch[c].coreDiv = stage1 ? 12'h000 : st.ch[c].coreDiv + 12'h001;
               end
               powLimit = 16'((17'h00001 << st.ch[c].prescale) - 17'h00001);
               tick     = stage1 && st.ch[c].powDiv == powLimit;
               if (stage1)
               begin
                  next_st.ch[c].powDiv = tick ? 16'h0000 : st.ch[c].powDiv + 16'h0001;
               end
               if (tick && st.ch[c].count != 16'h0000)
               begin
                  if (st.ch[c].count == 16'h0001)
                  begin
                     next_st.ch[c].count = st.ch[c].autoReloadOn ? st.ch[c].preload : 16'h0000;
                     next_st.ch[c].endPipe[0] = 1'b1;
                  end
                  else
                  begin
                     next_st.ch[c].count = st.ch[c].count - 16'h0001;
                  end
               end
            end

            // The zero event walks three core cycles before it lands in the flag.
            next_st.ch[c].endPipe[END_DELAY-1:1] = st.ch[c].endPipe[END_DELAY-2:0];
            if (!(tick && st.ch[c].count == 16'h0001))
            begin
               next_st.ch[c].endPipe[0] = 1'b0;
            end
            setFlags[BIT_END + CH_FLAG_STRIDE * c] = st.ch[c].endPipe[END_DELAY-1];
            tick = 1'b0;
         end

         // ************************************************************
         // Flags and mask
         // ************************************************************
         if (wr && adr == OFF_FLAG_CLEAR)
         begin
            clrFlags = wdat[NUM_FLAGS-1:0];
         end
         // A flag raised in the same cycle as its clear survives.
         next_st.flags = (st.flags & ~clrFlags) | setFlags;
         if (wr && adr == OFF_IRQ_ENABLE)
         begin
            next_st.irqMask = st.irqMask | wdat[NUM_FLAGS-1:0];
         end
         else if (wr && adr == OFF_IRQ_DISABLE)
         begin
            next_st.irqMask = st.irqMask & ~wdat[NUM_FLAGS-1:0];
         end
      end

      // ************************************************************
      // Clock power control
      // ************************************************************
      if (wr && adr == OFF_CLK_DISABLE && wdat[BIT_CLOCK_ON])
      begin
         next_st.timerClockOn = 1'b0;
      end
      else if (wr && adr == OFF_CLK_ENABLE && wdat[BIT_CLOCK_ON])
      begin
         next_st.timerClockOn = 1'b1;
      end

      // ************************************************************
      // Read decode
      // ************************************************************
      if (adr == OFF_CLK_FLAGS)
      begin
         rdat[BIT_CLOCK_ON] = st.timerClockOn;
      end
      else if (adr == OFF_EVENTS)
      begin
         rdat[NUM_FLAGS-1:0] = st.flags;
         rdat[BIT_CH_ON]     = st.ch[0].channelOn;
         rdat[BIT_CH_ON + 1] = st.ch[1].channelOn;
      end
      else if (adr == OFF_IRQ_MASK)
      begin
         rdat[NUM_FLAGS-1:0] = st.irqMask;
      end
      else if (adr == OFF_CH0_PRESC || adr == OFF_CH1_PRESC)
      begin
         rdat[PS_HI:PS_LO] = st.ch[adr[3]].prescale;
         rdat[PS_SEL]      = st.ch[adr[3]].dividerSourceSelect;
         rdat[PS_AUTO]     = st.ch[adr[3]].autoReloadOn;
         rdat[SC_HI:SC_LO] = st.ch[adr[3]].coreDivideValue;
      end
      else if (adr == OFF_CH0_PRELOAD || adr == OFF_CH1_PRELOAD)
      begin
         rdat[15:0] = st.ch[adr[3]].preload;
      end
      else if (adr == OFF_CH0_COUNT)
      begin
         rdat[15:0] = st.ch[0].count;
      end
      else if (adr == OFF_CH1_COUNT)
      begin
         rdat[15:0] = st.ch[1].count;
      end
      else
      begin
         rdat = 32'h00000000;
      end

      next_st.ack    = access;
      next_st.datOut = (access && !wbWeI) ? rdat : 32'h00000000;
      next_st.irq    = |(next_st.flags & next_st.irqMask);
   end

   // ************************************************************
   // State register
   // ************************************************************
   always_ff @(posedge clk_sys)
   begin
      if (!rstn)
      begin
         st <= '0;
      end
      else
      begin
         st <= next_st;
      end
   end

   assign wbDatO = st.datOut;
   assign wbAckO = st.ack;
   assign irq    = st.irq;
endmodule

// ==== rtl/sdt_pkg.sv ====
// Constants, register map and state types of the dual channel down timer.
package sdt_pkg;
   // ************************************************************
   // Register map
   // ************************************************************
   localparam int         ADR_W            = 12;
   localparam logic [11:0] OFF_CLK_ENABLE  = 12'h050;
   localparam logic [11:0] OFF_CLK_DISABLE = 12'h054;
   localparam logic [11:0] OFF_CLK_FLAGS   = 12'h058;
   localparam logic [11:0] OFF_CONTROL     = 12'h060;
   localparam logic [11:0] OFF_FLAG_CLEAR  = 12'h06C;
   localparam logic [11:0] OFF_EVENTS      = 12'h070;
   localparam logic [11:0] OFF_IRQ_ENABLE  = 12'h074;
   localparam logic [11:0] OFF_IRQ_DISABLE = 12'h078;
   localparam logic [11:0] OFF_IRQ_MASK    = 12'h07C;
   localparam logic [11:0] OFF_CH0_PRESC   = 12'h080;
   localparam logic [11:0] OFF_CH0_PRELOAD = 12'h084;
   localparam logic [11:0] OFF_CH1_PRESC   = 12'h088;
   localparam logic [11:0] OFF_CH1_PRELOAD = 12'h08C;
   localparam logic [11:0] OFF_CH0_COUNT   = 12'h200;
   localparam logic [11:0] OFF_CH1_COUNT   = 12'h204;
   localparam logic [11:0] CH_STRIDE       = 12'h008;

   // ************************************************************
   // Field positions
   // ************************************************************
   localparam int BIT_CLOCK_ON   = 1;
   localparam int BIT_SOFT_RESET = 0;
   localparam int BIT_CH_ENABLE  = 1;
   localparam int BIT_CH_DISABLE = 2;
   localparam int CH_CMD_STRIDE  = 2;
   localparam int BIT_END        = 0;
   localparam int BIT_DIS        = 1;
   localparam int BIT_LOAD       = 2;
   localparam int CH_FLAG_STRIDE = 3;
   localparam int BIT_CH_ON      = 24;
   localparam int NUM_FLAGS      = 6;
   localparam int NUM_CH         = 2;
   localparam int PS_LO          = 0;
   localparam int PS_HI          = 3;
   localparam int PS_SEL         = 4;
   localparam int PS_AUTO        = 5;
   localparam int SC_LO          = 8;
   localparam int SC_HI          = 18;
   localparam int END_DELAY      = 3;

   // ************************************************************
   // State types
   // ************************************************************
   typedef struct packed {
      logic [3:0]  prescale;
      logic        dividerSourceSelect;
      logic        autoReloadOn;
      logic [10:0] coreDivideValue;
      logic [15:0] preload;
      logic [15:0] count;
      logic        channelOn;
      logic        preloadPending;
      logic [11:0] coreDiv;
      logic [15:0] powDiv;
      logic [END_DELAY-1:0] endPipe;
   } sdt_chan_t;

   typedef struct packed {
      sdt_chan_t [NUM_CH-1:0] ch;
      logic                   timerClockOn;
      logic [NUM_FLAGS-1:0]   flags;
      logic [NUM_FLAGS-1:0]   irqMask;
      logic                   lowFreqPrev;
      logic                   ack;
      logic [31:0]            datOut;
      logic                   irq;
   } sdt_state_t;
endpackage

// ==== tb/sdt_timer_checker.sv ====
// Concurrent port checks for the dual channel down timer.
module sdt_timer_checker
   import sdt_pkg::*;
(
   input wire logic             clk_sys,
   input wire logic             rstn,
   input wire logic             wbCycI,
   input wire logic             wbStbI,
   input wire logic             wbWeI,
   input wire logic [ADR_W-1:0] wbAdrI,
   input wire logic [3:0]       wbSelI,
   input wire logic [31:0]      wbDatI,
   input wire logic [31:0]      wbDatO,
   input wire logic             wbAckO,
   input wire logic             lowFreqClock,
   input wire logic             irq
);
   // ************************************************************
   // Shadow of what software has written
   // ************************************************************
   logic       take;
   logic       wrEn;
   logic       clkTrk;
   logic [5:0] maskTrk;
   logic [9:0] rdWord;
   logic       rdLast;
   assign take = wbCycI && wbStbI && !wbAckO;
   assign wrEn = take && wbWeI && wbSelI[0];
   always_ff @(posedge clk_sys)
   begin
      if (!rstn)
      begin
         clkTrk  <= 1'b0;
         maskTrk <= 6'h0;
         rdLast  <= 1'b0;
         rdWord  <= 10'h0;
      end
      else
      begin
         rdLast <= take && !wbWeI;
         rdWord <= wbAdrI[11:2];
         if (wrEn)
         begin
            case ({wbAdrI[11:2], 2'b00})
               OFF_CLK_ENABLE:  clkTrk <= clkTrk | wbDatI[1];
               OFF_CLK_DISABLE: clkTrk <= clkTrk & ~wbDatI[1];
               OFF_CONTROL:     if (wbDatI[0]) maskTrk <= 6'h0;
               OFF_IRQ_ENABLE:  maskTrk <= maskTrk | wbDatI[5:0];
               OFF_IRQ_DISABLE: maskTrk <= maskTrk & ~wbDatI[5:0];
               default: ;
            endcase
         end
      end
   end

   // ************************************************************
   // Assertions
   // ************************************************************
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rstn);
   property p_ack_one; take |=> wbAckO; endproperty
   a_ack_one: assert property (p_ack_one) else $error("No ack one cycle after a request.");
   property p_ack_pulse; wbAckO |=> !wbAckO; endproperty
   a_ack_pulse: assert property (p_ack_pulse) else $error("Ack lasted more than one cycle.");
   property p_dat_idle; !wbAckO |-> wbDatO == 32'h0; endproperty
   a_dat_idle: assert property (p_dat_idle) else $error("Read data not zero outside ack.");
   property p_clk_view; wbAckO && rdLast && rdWord == OFF_CLK_FLAGS[11:2] |-> wbDatO == {30'h0, clkTrk, 1'b0};
   endproperty
   a_clk_view: assert property (p_clk_view) else $error("Clock power flag wrong.");
   property p_mask_view; wbAckO && rdLast && rdWord == OFF_IRQ_MASK[11:2] |-> wbDatO == {26'h0, maskTrk};
   endproperty
   a_mask_view: assert property (p_mask_view) else $error("Interrupt mask view wrong.");
   property p_irq_mask; irq |-> maskTrk != 6'h0 || $past(maskTrk) != 6'h0; endproperty
   a_irq_mask: assert property (p_irq_mask) else $error("Interrupt high with empty mask.");
   property p_events_layout; wbAckO && rdLast && rdWord == OFF_EVENTS[11:2] |-> wbDatO[31:26] == 6'h0
      && wbDatO[23:6] == 18'h0; endproperty
   a_events_layout: assert property (p_events_layout) else $error("Event flags outside their fields.");
   property p_count_width; wbAckO && rdLast && (rdWord == OFF_CH0_COUNT[11:2] || rdWord == OFF_CH1_COUNT[11:2])
      |-> wbDatO[31:16] == 16'h0; endproperty
   a_count_width: assert property (p_count_width) else $error("Count wider than 16 bits.");
   property p_soft_irq; wrEn && wbAdrI[11:2] == OFF_CONTROL[11:2] && wbDatI[0] |-> ##[1:2] !irq; endproperty
   a_soft_irq: assert property (p_soft_irq) else $error("Interrupt survived a soft reset.");
endmodule

bind sdt_timer sdt_timer_checker u_chk (.clk_sys, .rstn, .wbCycI, .wbStbI, .wbWeI, .wbAdrI, .wbSelI, .wbDatI,
   .wbDatO, .wbAckO, .lowFreqClock, .irq);

// ==== tb/tb_dual_channel_down_timer.sv ====
// Self-checking bench for the dual channel down timer.
module tb_dual_channel_down_timer;
   import sdt_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {logic we; logic [11:0] adr; logic [31:0] dat;} sdt_row_t;
   logic        clk_sys = 1'b0;
   logic        rstn = 1'b0;
   logic        wbCycI = 1'b0;
   logic        wbStbI = 1'b0;
   logic        wbWeI = 1'b0;
   logic [11:0] wbAdrI = 12'h0;
   logic [3:0]  wbSelI = 4'hF;
   logic [31:0] wbDatI = 32'h0;
   logic [31:0] wbDatO;
   logic        wbAckO;
   logic        lowFreqClock = 1'b0;
   logic        irq;
   logic [31:0] q;
   logic [31:0] h;
   int          bad_count = 0;
   int          checks_done = 0;
   sdt_row_t    rows [26] = '{
      '{1'b0, 12'h058, 32'h0}, '{1'b0, 12'h070, 32'h0}, '{1'b0, 12'h07C, 32'h0},
      '{1'b0, 12'h080, 32'h0}, '{1'b0, 12'h084, 32'h0}, '{1'b0, 12'h088, 32'h0}, '{1'b0, 12'h08C, 32'h0},
      '{1'b0, 12'h200, 32'h0}, '{1'b0, 12'h204, 32'h0}, '{1'b0, 12'h064, 32'h0},
      '{1'b1, 12'h050, 32'h2}, '{1'b0, 12'h058, 32'h2}, '{1'b1, 12'h050, 32'h1},
      '{1'b1, 12'h054, 32'h1}, '{1'b0, 12'h058, 32'h2},
      '{1'b1, 12'h074, 32'h3F}, '{1'b0, 12'h07C, 32'h3F}, '{1'b1, 12'h078, 32'h3E}, '{1'b0, 12'h07C, 32'h1},
      '{1'b1, 12'h080, 32'h0}, '{1'b1, 12'h084, 32'h5}, '{1'b0, 12'h084, 32'h5},
      '{1'b1, 12'h088, 32'h122}, '{1'b1, 12'h08C, 32'h64}, '{1'b0, 12'h088, 32'h122}, '{1'b0, 12'h08C, 32'h64}};

   sdt_timer uut (.clk_sys, .rstn, .wbCycI, .wbStbI, .wbWeI, .wbAdrI, .wbSelI, .wbDatI, .wbDatO, .wbAckO,
      .lowFreqClock, .irq);

   initial
   begin
      forever #20 clk_sys = ~clk_sys;
   end

   // The slow clock is made on the core edge, as the design takes it to be synchronous.
   always
   begin
      repeat (8) @(posedge clk_sys);
      lowFreqClock <= ~lowFreqClock;
   end

   task automatic summarize();
      $display("Checks %0d, errors %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         $display("Error at %0t: got %h expected %h", $time, got, exp);
         bad_count++;
      end
   endtask

   // One classic cycle; a silent slave is caught by the watchdog, not here.
   task automatic acc(input logic [11:0] a, input logic w, input logic [31:0] d, output logic [31:0] r);
      @(posedge clk_sys);
      wbCycI <= 1'b1;
      wbStbI <= 1'b1;
      wbWeI  <= w;
      wbAdrI <= a;
      wbDatI <= d;
      do
      begin
         @(posedge clk_sys);
      end
      while (wbAckO !== 1'b1);
      r = wbDatO;
      wbCycI <= 1'b0;
      wbStbI <= 1'b0;
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] r;
      acc(a, 1'b1, d, r);
   endtask

   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      logic [31:0] r;
      acc(a, 1'b0, 32'h0, r);
      check(r, e);
   endtask

   initial
   begin
      repeat (20000) @(posedge clk_sys);
      bad_count++;
      summarize();
   end

   initial
   begin
      repeat (4) @(posedge clk_sys);
      rstn <= 1'b1;
      foreach (rows[i])
      begin
         acc(rows[i].adr, rows[i].we, rows[i].dat, q);
         if (!rows[i].we)
            check(q, rows[i].dat);
      end
      wr(OFF_CONTROL, 32'h2);
      rd(OFF_EVENTS, 32'h0100_0004);
      check({31'h0, irq}, 32'h0);
      repeat (30) @(posedge clk_sys);
      rd(OFF_CH0_COUNT, 32'h0);
      rd(OFF_EVENTS, 32'h0100_0005);
      check({31'h0, irq}, 32'h1);
      wr(OFF_FLAG_CLEAR, 32'h1);
      rd(OFF_EVENTS, 32'h0100_0004);
      check({31'h0, irq}, 32'h0);
      wr(OFF_CH0_PRELOAD, 32'h9);
      rd(OFF_CH0_PRELOAD, 32'h5);
      wr(OFF_CONTROL, 32'h8);
      repeat (400) @(posedge clk_sys);
      acc(OFF_CH1_COUNT, 1'b0, 32'h0, q);
      check({31'h0, q >= 32'd73 && q <= 32'd77}, 32'h1);
      wr(OFF_CONTROL, 32'h18);
      rd(OFF_EVENTS, 32'h0100_0034);
      acc(OFF_CH1_COUNT, 1'b0, 32'h0, h);
      repeat (40) @(posedge clk_sys);
      rd(OFF_CH1_COUNT, h);
      wr(OFF_CONTROL, 32'h8);
      repeat (80) @(posedge clk_sys);
      acc(OFF_CH1_COUNT, 1'b0, 32'h0, q);
      check({31'h0, q < h && q + 32'd16 > h}, 32'h1);
      repeat (1500) @(posedge clk_sys);
      acc(OFF_EVENTS, 1'b0, 32'h0, q);
      check(q & 32'h8, 32'h8);
      acc(OFF_CH1_COUNT, 1'b0, 32'h0, q);
      check({31'h0, q != 32'h0}, 32'h1);
      wr(OFF_CONTROL, 32'h1);
      rd(OFF_CLK_FLAGS, 32'h2);
      rd(OFF_EVENTS, 32'h0);
      rd(OFF_IRQ_MASK, 32'h0);
      rd(OFF_CH1_PRESC, 32'h0);
      rd(OFF_CH1_COUNT, 32'h0);
      wr(OFF_CH0_PRESC, 32'h10);
      wr(OFF_CH0_PRELOAD, 32'h10);
      wr(OFF_CONTROL, 32'h2);
      repeat (160) @(posedge clk_sys);
      acc(OFF_CH0_COUNT, 1'b0, 32'h0, q);
      check({31'h0, q >= 32'd4 && q <= 32'd8}, 32'h1);
      wr(OFF_CLK_DISABLE, 32'h2);
      rd(OFF_CLK_FLAGS, 32'h0);
      summarize();
   end
endmodule
